// ---- design/sstseq_pkg.sv ----
package sstseq_pkg;

   // Command values written into the miscellaneous command setting.
   localparam logic [7:0] CMD_UNPOWERED = 8'h07;
   localparam logic [7:0] CMD_POWERED = 8'h08;

   // Gate step time and powered step time.
   localparam int GATE_ON_US = 500;
   localparam int CLK_MHZ = 200;
   localparam int GATE_ON_CYC = GATE_ON_US * CLK_MHZ;
   localparam int POLE_ON_US = 1000;
   localparam int POLE_ON_CYC = POLE_ON_US * CLK_MHZ;
   // Wide enough for the longest contactor timeout in clock cycles.
   localparam int CNT_W = 34;

   // Reset values.
   localparam logic [5:0] GATES_RST = 6'h00;
   localparam logic [2:0] GATE_IDX_RST = 3'h0;

   // Line timeout of zero skips the line contactor steps; a zero bypass timeout expires at once.
   localparam logic [15:0] TIMEOUT_OFF = 16'h0000;
   // Timeout unit is one millisecond.
   localparam int MS_CYC = 1000 * CLK_MHZ;

   typedef enum {
      SST_IDLE,
      SST_LINE_ON,
      SST_LINE_OFF,
      SST_BYP_ON,
      SST_BYP_OFF,
      SST_GATE_SEQ,
      SST_GATE_ALL,
      SST_DONE,
      SST_P_POLE,
      SST_P_CT
   } sst_state_t;

   typedef struct packed {
      logic abnormal_exit;
      logic line_contactor;
      logic bypass_contactor;
      logic bad_power_device;
      logic ground;
      logic transformer_placement;
      logic phase_order;
   } sst_fault_t;

   typedef struct packed {
      logic line_voltage;
      logic [2:0] phase_current;
      logic ground_current;
      logic [1:0] phase_seq;
   } sst_sense_t;

endpackage

// ---- design/sstseq_timer.sv ----
`timescale 1ns/10ps
module sstseq_timer
   import sstseq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic restart,
   input wire logic [CNT_W-1:0] limit,
   // Status
   output logic expired
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (restart) begin
         next_count = '0;
      end else if (count < limit) begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign expired = !restart && (count >= limit);

endmodule

// ---- design/sstseq_top.sv ----
`timescale 1ns/10ps
module sstseq_top
   import sstseq_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Command
   input wire logic CMD_WRITE,
   input wire logic [7:0] CMD_VALUE,
   input wire logic ENTER_KEY,
   // Configuration
   input wire logic [15:0] LINE_TIMEOUT_MS,
   input wire logic LINE_CONFIRM_ASSIGNED,
   input wire logic [15:0] BYPASS_TIMEOUT_MS,
   input wire logic BYPASS_FAN_DUTY,
   input wire logic BYPASS_CONFIRM_ASSIGNED,
   input wire logic [1:0] EXPECTED_PHASE_ORDER,
   // Feedback and sensing
   input wire logic LINE_FEEDBACK,
   input wire logic BYPASS_FEEDBACK,
   input wire sst_sense_t SENSE,
   input wire logic REG_CURRENT_OK,
   // Outputs to the power section
   output logic RUN_RELAY,
   output logic BYPASS_RELAY,
   output logic UP_TO_SPEED_RELAY,
   output logic [5:0] GATES,
   output logic [2:0] POLE_ENABLE,
   output logic CURRENT_INJECT,
   // Status
   output logic BUSY,
   output logic POWERED_MODE,
   output logic [2:0] GATE_INDEX,
   output logic TESTS_COMPLETED,
   output sst_fault_t FAULTS
);

   sst_state_t state;
   sst_state_t next_state;
   logic [2:0] sub;
   logic [2:0] next_sub;
   logic powered;
   logic next_powered;
   sst_fault_t faults;
   sst_fault_t next_faults;
   logic restart;
   logic [CNT_W-1:0] limit;
   logic expired;
   logic enter_prev;
   logic enter_press;
   logic next_run_relay;
   logic next_bypass_relay;
   logic next_up_to_speed_relay;
   logic [5:0] next_gates;
   logic [2:0] next_gate_index;
   logic [2:0] next_pole_enable;
   logic next_current_inject;
   logic next_tests_completed;
   logic next_busy;

   function automatic logic [CNT_W-1:0] ms_to_cyc(input logic [15:0] ms);
      ms_to_cyc = CNT_W'(ms) * CNT_W'(MS_CYC);
   endfunction

   sstseq_timer u_timer (
      .clk(REF_CLK),
      .rst(RST),
      .restart(restart),
      .limit(limit),
      .expired(expired)
   );

   assign enter_press = ENTER_KEY && !enter_prev;

   always_comb begin
      next_state = state;
      next_sub = sub;
      next_powered = powered;
      next_faults = faults;
      restart = 1'b0;
      limit = CNT_W'(GATE_ON_CYC);
      case (state)
         SST_LINE_ON, SST_LINE_OFF: limit = ms_to_cyc(LINE_TIMEOUT_MS);
         SST_BYP_ON, SST_BYP_OFF: limit = ms_to_cyc(BYPASS_TIMEOUT_MS);
         SST_P_POLE, SST_P_CT: limit = CNT_W'(POLE_ON_CYC);
         default: limit = CNT_W'(GATE_ON_CYC);
      endcase
      case (state)
         SST_IDLE: begin
            restart = 1'b1;
            next_sub = 3'h0;
            if (CMD_WRITE && CMD_VALUE == CMD_UNPOWERED) begin
               next_faults = '0;
               next_powered = 1'b0;
               next_state = (LINE_TIMEOUT_MS == TIMEOUT_OFF) ? SST_BYP_ON : SST_LINE_ON;
            end else if (CMD_WRITE && CMD_VALUE == CMD_POWERED) begin
               next_faults = '0;
               next_powered = 1'b1;
               next_state = SST_P_POLE;
            end
         end
         SST_LINE_ON, SST_LINE_OFF: begin
            if (enter_press || !LINE_CONFIRM_ASSIGNED ||
                LINE_FEEDBACK == (state == SST_LINE_ON)) begin
               restart = 1'b1;
               next_state = (state == SST_LINE_ON) ? SST_LINE_OFF : SST_BYP_ON;
            end else if (expired) begin
               next_faults.line_contactor = 1'b1;
               next_state = SST_IDLE;
            end
         end
         SST_BYP_ON, SST_BYP_OFF: begin
            if (enter_press || (BYPASS_FAN_DUTY && !BYPASS_CONFIRM_ASSIGNED) ||
                BYPASS_FEEDBACK == (state == SST_BYP_ON)) begin
               restart = 1'b1;
               next_state = (state == SST_BYP_ON) ? SST_BYP_OFF : SST_GATE_SEQ;
            end else if (expired) begin
               next_faults.bypass_contactor = 1'b1;
               next_state = SST_IDLE;
            end
         end
         SST_GATE_SEQ: begin
            if (enter_press) begin
               restart = 1'b1;
               next_sub = 3'h0;
               next_state = SST_GATE_ALL;
            end else if (expired) begin
               restart = 1'b1;
               next_sub = sub + 3'h1;
               if (sub == 3'h5) begin
                  next_sub = 3'h0;
                  next_state = SST_GATE_ALL;
               end
            end
         end
         SST_GATE_ALL: begin
            if (enter_press || expired) begin
               restart = 1'b1;
               next_state = SST_DONE;
            end
         end
         SST_DONE: begin
            if (enter_press || expired) begin
               next_state = SST_IDLE;
            end
         end
         SST_P_POLE: begin
            if (|SENSE.phase_current || SENSE.ground_current) begin
               if (SENSE.ground_current) begin
                  next_faults.ground = 1'b1;
               end else begin
                  next_faults.bad_power_device = 1'b1;
               end
               next_state = SST_IDLE;
            end else if (enter_press || expired) begin
               restart = 1'b1;
               next_sub = sub + 3'h1;
               if (sub == 3'h2 || enter_press) begin
                  next_sub = 3'h0;
                  next_state = SST_P_CT;
               end
            end
         end
         SST_P_CT: begin
            if (|(SENSE.phase_current & ~(3'h1 << sub))) begin
               next_faults.transformer_placement = 1'b1;
               next_state = SST_IDLE;
            end else if (expired && !REG_CURRENT_OK) begin
               next_faults.bad_power_device = 1'b1;
               next_state = SST_IDLE;
            end else if (enter_press || expired) begin
               restart = 1'b1;
               next_sub = sub + 3'h1;
               if (sub == 3'h2 || enter_press) begin
                  next_sub = 3'h0;
                  next_state = SST_DONE;
               end
            end
         end
         default: next_state = SST_IDLE;
      endcase
      if (state != SST_IDLE && state != SST_DONE) begin
         if (!powered && (SENSE.line_voltage || |SENSE.phase_current)) begin
            next_faults = faults;
            next_faults.abnormal_exit = 1'b1;
            next_state = SST_IDLE;
         end else if (powered && !SENSE.line_voltage) begin
            next_faults = faults;
            next_faults.abnormal_exit = 1'b1;
            next_state = SST_IDLE;
         end else if (powered && SENSE.phase_seq != EXPECTED_PHASE_ORDER) begin
            next_faults = faults;
            next_faults.phase_order = 1'b1;
            next_state = SST_IDLE;
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state <= SST_IDLE;
         sub <= 3'h0;
         powered <= 1'b0;
         faults <= '0;
         enter_prev <= 1'b0;
      end else begin
         state <= next_state;
         sub <= next_sub;
         powered <= next_powered;
         faults <= next_faults;
         enter_prev <= ENTER_KEY;
      end
   end

   // Outputs are decoded from the next state so they change with the state register.
   always_comb begin
      next_run_relay = (next_state == SST_LINE_ON);
      next_bypass_relay = (next_state == SST_BYP_ON);
      next_up_to_speed_relay = (next_state == SST_BYP_ON);
      next_gates = GATES_RST;
      next_gate_index = GATE_IDX_RST;
      next_pole_enable = 3'h0;
      if (next_state == SST_GATE_SEQ) begin
         next_gates = 6'(6'h01 << next_sub);
         next_gate_index = next_sub + 3'h1;
      end else if (next_state == SST_GATE_ALL) begin
         next_gates = 6'h3f;
      end
      if (next_state == SST_P_POLE || next_state == SST_P_CT) begin
         next_pole_enable = 3'(3'h1 << next_sub);
      end
      next_current_inject = (next_state == SST_P_CT);
      next_tests_completed = (next_state == SST_DONE);
      next_busy = (next_state != SST_IDLE);
   end

   // Registered outputs decoded from the next state, with POWERED_MODE and FAULTS taken from next_powered and next_faults.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RUN_RELAY <= 1'b0;
         BYPASS_RELAY <= 1'b0;
         UP_TO_SPEED_RELAY <= 1'b0;
         GATES <= GATES_RST;
         GATE_INDEX <= GATE_IDX_RST;
         POLE_ENABLE <= 3'h0;
         CURRENT_INJECT <= 1'b0;
         TESTS_COMPLETED <= 1'b0;
         BUSY <= 1'b0;
         POWERED_MODE <= 1'b0;
         FAULTS <= '0;
      end else begin
         RUN_RELAY <= next_run_relay;
         BYPASS_RELAY <= next_bypass_relay;
         UP_TO_SPEED_RELAY <= next_up_to_speed_relay;
         GATES <= next_gates;
         GATE_INDEX <= next_gate_index;
         POLE_ENABLE <= next_pole_enable;
         CURRENT_INJECT <= next_current_inject;
         TESTS_COMPLETED <= next_tests_completed;
         BUSY <= next_busy;
         POWERED_MODE <= next_powered;
         FAULTS <= next_faults;
      end
   end

endmodule

// ---- tb/sstseq_plant.sv ----
`timescale 1ns/10ps
module sstseq_plant
   import sstseq_pkg::*;
(
   // Coils and drive
   input wire logic clk,
   input wire logic run,
   input wire logic byp,
   input wire logic [2:0] pole,
   input wire logic inj,
   // Plant condition
   input wire logic line_on,
   input wire logic shorted,
   input wire logic gnd,
   input wire logic swap,
   input wire logic [1:0] seq,
   // Feedback
   output logic run_fb = 1'b0,
   output logic byp_fb = 1'b0,
   output sst_sense_t sense
);
   logic [2:0] i;
   // Auxiliary contacts answer one cycle after their coils.
   always @(posedge clk) begin
      run_fb <= run;
      byp_fb <= byp;
   end
   // A shorted pole or a misplaced transformer shows current on some phase.
   assign i = (shorted || inj) ? (swap ? {pole[1:0], pole[2]} : pole) : 3'h0;
   assign sense = {line_on, i, gnd && |i, seq};
endmodule

// ---- tb/sstseq_sva.sv ----
`timescale 1ns/10ps
module sstseq_sva
   import sstseq_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Inputs
   input wire logic CMD_WRITE,
   input wire logic [7:0] CMD_VALUE,
   input wire sst_sense_t SENSE,
   // Outputs
   input wire logic [5:0] GATES,
   input wire logic [2:0] POLE_ENABLE,
   input wire logic BUSY,
   input wire logic POWERED_MODE,
   input wire logic [2:0] GATE_INDEX,
   input wire logic TESTS_COMPLETED,
   input wire sst_fault_t FAULTS
);
   logic go;
   assign go = CMD_WRITE && !BUSY;
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   a_std_start: assert property (
      go && CMD_VALUE == CMD_UNPOWERED |=> BUSY && !POWERED_MODE) else $error("no start");
   a_pow_start: assert property (
      go && CMD_VALUE == CMD_POWERED |=> BUSY && POWERED_MODE) else $error("no start");
   a_other_ignored: assert property (
      go && CMD_VALUE != CMD_UNPOWERED && CMD_VALUE != CMD_POWERED |=> !BUSY) else $error("taken");
   a_gate_single: assert property (
      GATE_INDEX != 3'h0 |-> GATES == 6'h01 << (GATE_INDEX - 3'h1)) else $error("gate");
   a_gate_order: assert property (
      GATE_INDEX > 3'h1 && $changed(GATE_INDEX) |-> $past(GATE_INDEX) == GATE_INDEX - 3'h1)
      else $error("gate order");
   a_abnormal_exit: assert property (
      BUSY && !TESTS_COMPLETED && !POWERED_MODE && (SENSE.line_voltage || |SENSE.phase_current)
      |=> FAULTS.abnormal_exit && !BUSY) else $error("no exit");
   a_line_loss: assert property (
      BUSY && !TESTS_COMPLETED && POWERED_MODE && !SENSE.line_voltage |=> FAULTS.abnormal_exit)
      else $error("line loss");
   a_pole_single: assert property (
      POLE_ENABLE != 3'h0 |-> $onehot(POLE_ENABLE) && POWERED_MODE) else $error("pole");
endmodule
bind sstseq_top sstseq_sva u_sva (.REF_CLK(REF_CLK), .RST(RST), .CMD_WRITE(CMD_WRITE),
   .CMD_VALUE(CMD_VALUE), .SENSE(SENSE), .GATES(GATES), .POLE_ENABLE(POLE_ENABLE),
   .BUSY(BUSY), .POWERED_MODE(POWERED_MODE), .GATE_INDEX(GATE_INDEX),
   .TESTS_COMPLETED(TESTS_COMPLETED), .FAULTS(FAULTS));

// ---- tb/sstseq_top_tb.sv ----
`timescale 1ns/10ps
module sstseq_top_tb
   import sstseq_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, ent = 1'b0, cut = 1'b0, lca = 1'b1, fan = 1'b0;
   logic bca = 1'b1, line_on = 1'b0, shorted = 1'b0, gnd = 1'b0, swap = 1'b0;
   logic [7:0] val = 8'h00;
   logic [15:0] lto = 16'h0001;
   logic [1:0] epo = 2'h0, seq = 2'h0;
   logic run_fb, byp_fb, run, byp, up_to_speed_relay, inj, busy, pmode, done;
   logic [5:0] gates;
   logic [2:0] pole, gidx;
   sst_sense_t sense;
   sst_fault_t faults;
   int bad_count = 0, comparisons = 0, seed = 59524;
   always #2.5 clk = !clk;
   sstseq_top u_dut (.REF_CLK(clk), .RST(rst), .CMD_WRITE(wr), .CMD_VALUE(val), .ENTER_KEY(ent),
      .LINE_TIMEOUT_MS(lto), .LINE_CONFIRM_ASSIGNED(lca), .BYPASS_TIMEOUT_MS(16'h0001),
      .BYPASS_FAN_DUTY(fan), .BYPASS_CONFIRM_ASSIGNED(bca), .EXPECTED_PHASE_ORDER(epo),
      .LINE_FEEDBACK(run_fb && !cut), .BYPASS_FEEDBACK(byp_fb && !cut), .SENSE(sense),
      .REG_CURRENT_OK(inj), .RUN_RELAY(run), .BYPASS_RELAY(byp), .UP_TO_SPEED_RELAY(up_to_speed_relay),
      .GATES(gates), .POLE_ENABLE(pole), .CURRENT_INJECT(inj), .BUSY(busy),
      .POWERED_MODE(pmode), .GATE_INDEX(gidx), .TESTS_COMPLETED(done), .FAULTS(faults));
   sstseq_plant u_plant (.clk(clk), .run(run), .byp(byp || up_to_speed_relay), .pole(pole), .inj(inj),
      .line_on(line_on), .shorted(shorted), .gnd(gnd), .swap(swap), .seq(seq),
      .run_fb(run_fb), .byp_fb(byp_fb), .sense(sense));
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic hit(int k);
      case (k)
         0: return !busy;
         1: return up_to_speed_relay;
         2: return gates == 6'h3f;
         3: return done;
         default: return gidx == 3'(k - 3);
      endcase
   endfunction
   function automatic logic [7:0] fault_of(int c);
      return c == 0 ? 8'h04 : c == 1 ? 8'h08 : c == 2 ? 8'h02 : c == 3 ? 8'h01 :
         c == 4 ? 8'h40 : 8'h00;
   endfunction
   task automatic wait_for(int k, int lim);
      for (int n = 0; n < lim && hit(k) !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      check("wait", 8'h01, 8'(hit(k)));
   endtask
   task automatic cmd(logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      val <= v;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic press();
      @(posedge clk);
      ent <= 1'b1;
      repeat (2) @(posedge clk);
      ent <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic run_std(int t);
      cmd(CMD_UNPOWERED);
      check("run", 8'(t != 1), 8'(run));
      wait_for(1, 200);
      check("bypass", 8'h01, 8'(byp));
      cmd(CMD_POWERED);
      check("mode", 8'h00, 8'(pmode));
      // Enter ends the whole sequential gate step, so only the first gate is seen.
      wait_for(4, 200);
      check("gates", 8'h01, 8'(gates));
      press();
      wait_for(2, 20);
      press();
      wait_for(3, 20);
      press();
      wait_for(0, 20);
      check("faults", 8'h00, 8'(faults));
      $display("standard test %0d done", t);
   endtask
   initial begin
      logic [7:0] v;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      epo <= 2'($random(seed));
      @(posedge clk);
      #1;
      check("busy", 8'h00, 8'(busy));
      v = 8'($random(seed));
      v = (v == CMD_UNPOWERED || v == CMD_POWERED) ? 8'h00 : v;
      cmd(v);
      check("refused", 8'h00, 8'(busy));
      for (int t = 0; t < 3; t++) begin
         lto <= (t == 1) ? TIMEOUT_OFF : 16'h0001;
         lca <= (t != 2);
         bca <= (t != 2);
         fan <= (t == 2);
         cut <= (t == 2);
         run_std(t);
      end
      cmd(CMD_UNPOWERED);
      wait_for(4, 200);
      line_on <= 1'b1;
      wait_for(0, 20);
      check("faults", fault_of(4), 8'(faults));
      for (int c = 0; c < 6; c++) begin
         shorted <= (c < 2);
         gnd <= (c == 0);
         swap <= (c == 2);
         seq <= epo + 2'(c == 3);
         cmd(CMD_POWERED);
         check("pole", 8'h01, 8'(pole));
         line_on <= (c != 4);
         repeat ((c == 2) ? 3 : (c == 5) ? 7 : 0) press();
         wait_for(0, 100);
         check("faults", fault_of(c), 8'(faults));
         line_on <= 1'b1;
         $display("powered test %0d done", c);
      end
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule
